// File: hdl/ezr_change_flag.sv
// Purpose: Sticky change flag for one status level
// Assumes: Level input synchronous to mclk
// Notes:   A change in the cycle of a clear still sets the flag
`timescale 1ns/100ps
`default_nettype none
module ezr_change_flag (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cond,   // Watched level
    input wire logic clear,  // Clear request from the host port
    output logic change,     // One-cycle pulse on any edge of cond
    output logic flag        // Sticky change flag
);
    import ezr_pkg::*;

    // All state of the cell
    typedef struct packed {
        logic prev;
        logic flag;
    } ezr_cf_state_t;

    ezr_cf_state_t st;
    ezr_cf_state_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // Next state: edge detect, set wins over clear
    always_comb begin
        next_st = st;
        next_st.prev = cond;
        next_st.flag = (st.flag & ~clear) | change;
    end

    assign change = cond ^ st.prev;
    assign flag = st.flag;

    ////////////////////////////////////////////////////////////////////////
    // State register, synchronous active-low reset
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_change_sets_flag: assert property (@(posedge mclk) disable iff (!resetn)
        change |=> flag) else $error("change did not set flag");
    a_flag_holds_uncleared: assert property (@(posedge mclk) disable iff (!resetn)
        (flag && !clear) |=> flag) else $error("flag dropped without clear");
    a_clear_drops_flag: assert property (@(posedge mclk) disable iff (!resetn)
        (clear && !change) |=> !flag) else $error("clear left flag set");
endmodule
`default_nettype wire

// File: hdl/ezr_pkg.sv
// Purpose: Shared constants for the receive alarm interrupt register block
// Assumes: Byte-wide parallel register port, 4-bit register address
// Notes:   Offsets, bit positions and reset values live here, but sa7_zero and the flag cells reset to zero in their own modules
package ezr_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [3:0] OFS_EZ_STATUS = 4'h0; // Excess-zero / Sa7 status
    localparam logic [3:0] OFS_EZ_ENABLE = 4'h1; // excess_zero_irq_enable
    localparam logic [3:0] OFS_LC_STATUS = 4'h2; // los_crc_irq_status
    localparam logic [3:0] OFS_LC_ENABLE = 4'h3; // los_crc_irq_enable
    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_EZ_FLAG = 0;  // excess_zero_change_flag
    localparam int BIT_SA7_FLAG = 1; // Sa7 change flag
    localparam int BIT_SA7_STATE = 5; // Live Sa7-equals-zero state
    localparam int BIT_EXZ_EN = 0;   // excess_zero_change_en
    localparam int BIT_SA7_EN = 1;   // natbit7_zero_change_en
    localparam int BIT_CRC_FLAG = 2; // crc_mf_lock_change_flag
    localparam int BIT_LOS_FLAG = 3; // rx_signal_loss_change_flag
    localparam int BIT_TS16 = 4;     // ts16_all_ones_alarm live state
    localparam int BIT_CRC_EN = 2;   // Inverted enable, zero enables
    localparam int BIT_LOS_EN = 3;   // rx_signal_loss_change_en, zero enables
    ////////////////////////////////////////////////////////////////////////
    // Reset values and counts
    localparam logic [1:0] RST_EZ_ENABLE = 2'h0;
    localparam logic [3:0] RST_LC_ENABLE = 4'h0;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [2:0] RST_SA7_HIST = 3'h0;
    localparam int SA7_WINDOW = 3; // Observations kept
    localparam logic [1:0] SA7_DECLARE_MIN = 2'h2; // Zeros needed in window
endpackage

// File: hdl/ezr_rx_alarm_irq.sv
// Purpose: Interrupt enables and status for receive alarm change events
// Assumes: Detector levels and register strobes synchronous to mclk
// Notes:   Flags clear on read of their register or on write of a one
`timescale 1ns/100ps
`default_nettype none
module ezr_rx_alarm_irq (
    input wire logic mclk,
    input wire logic resetn,
    // Line-side detector inputs
    input wire logic sa7_valid,        // One-cycle strobe per Sa7 observation
    input wire logic sa7_bit,          // Received Sa7 national bit
    input wire logic excess_zero_cond, // Excessive-zero condition level
    input wire logic ts16_all_ones_alarm, // Time-slot-16 all-ones alarm level
    input wire logic rx_signal_loss,   // Receive loss-of-signal level
    input wire logic crc_mf_lock,      // CRC multiframe lock level
    // Parallel microprocessor port
    input wire logic cs,               // Chip select
    input wire logic rd,               // Read strobe, one cycle
    input wire logic wr,               // Write strobe, one cycle
    input wire logic [ezr_pkg::ADDR_W-1:0] addr,
    input wire logic [ezr_pkg::DATA_W-1:0] wdata,
    output logic [ezr_pkg::DATA_W-1:0] rdata, // Registered read data
    output logic irq                   // Interrupt request, active high
);
    import ezr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State of the block
    typedef struct packed {
        logic [1:0] ez_en;      // excess_zero_irq_enable bits 1:0
        logic [3:0] lc_en;      // los_crc_irq_enable bits 3:0
        logic [2:0] sa7_hist;   // Last three observations, one means zero
        logic sa7_zero;         // Sa7-equals-zero declared
        logic [DATA_W-1:0] rdata;
    } ezr_state_t;

    ezr_state_t st;
    ezr_state_t next_st;

    // Decoded accesses
    logic rd_ez;
    logic rd_lc;
    logic wr_ez;
    logic wr_lc;
    logic wr_en_ez;
    logic wr_en_lc;
    // Flag cells
    logic ez_change;
    logic ez_flag;
    logic sa7_change;
    logic sa7_flag;
    logic los_change;
    logic los_flag;
    logic crc_change;
    logic crc_flag;
    // Scratch for the Sa7 window
    logic [2:0] hist_new;
    logic [1:0] zero_cnt;

    assign rd_ez = cs & rd & (addr == OFS_EZ_STATUS);
    assign rd_lc = cs & rd & (addr == OFS_LC_STATUS);
    assign wr_ez = cs & wr & (addr == OFS_EZ_STATUS);
    assign wr_lc = cs & wr & (addr == OFS_LC_STATUS);
    assign wr_en_ez = cs & wr & (addr == OFS_EZ_ENABLE);
    assign wr_en_lc = cs & wr & (addr == OFS_LC_ENABLE);

    ////////////////////////////////////////////////////////////////////////
    // Change flags: read clears the register, write of one clears a bit
    ezr_change_flag u_ez_flag (
        .mclk(mclk),
        .resetn(resetn),
        .cond(excess_zero_cond),
        .clear(rd_ez | (wr_ez & wdata[BIT_EZ_FLAG])),
        .change(ez_change),
        .flag(ez_flag)
    );
    ezr_change_flag u_sa7_flag (
        .mclk(mclk),
        .resetn(resetn),
        .cond(st.sa7_zero),
        .clear(rd_ez | (wr_ez & wdata[BIT_SA7_FLAG])),
        .change(sa7_change),
        .flag(sa7_flag)
    );
    ezr_change_flag u_los_flag (
        .mclk(mclk),
        .resetn(resetn),
        .cond(rx_signal_loss),
        .clear(rd_lc | (wr_lc & wdata[BIT_LOS_FLAG])),
        .change(los_change),
        .flag(los_flag)
    );
    ezr_change_flag u_crc_flag (
        .mclk(mclk),
        .resetn(resetn),
        .cond(crc_mf_lock),
        .clear(rd_lc | (wr_lc & wdata[BIT_CRC_FLAG])),
        .change(crc_change),
        .flag(crc_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state: Sa7 window, enables, read data
    always_comb begin
        next_st = st;
        hist_new = {st.sa7_hist[1:0], ~sa7_bit};
        zero_cnt = 2'({1'b0, hist_new[0]}) + 2'({1'b0, hist_new[1]}) + 2'({1'b0, hist_new[2]});
        // Sa7 zero declared on two of three, cleared otherwise
        if (sa7_valid) begin
            next_st.sa7_hist = hist_new;
            next_st.sa7_zero = (zero_cnt >= SA7_DECLARE_MIN);
        end
        // Enable register writes
        if (wr_en_ez) begin
            next_st.ez_en = wdata[1:0];
        end
        if (wr_en_lc) begin
            next_st.lc_en = wdata[3:0];
        end
        // Read data, unmapped offsets read zero
        if (cs && rd) begin
            next_st.rdata = '0;
            unique case (addr)
                OFS_EZ_STATUS: begin
                    next_st.rdata[BIT_SA7_STATE] = st.sa7_zero;
                    next_st.rdata[BIT_SA7_FLAG] = sa7_flag;
                    next_st.rdata[BIT_EZ_FLAG] = ez_flag;
                end
                OFS_EZ_ENABLE: begin
                    next_st.rdata[1:0] = st.ez_en;
                end
                OFS_LC_STATUS: begin
                    next_st.rdata[BIT_TS16] = ts16_all_ones_alarm;
                    next_st.rdata[BIT_LOS_FLAG] = los_flag;
                    next_st.rdata[BIT_CRC_FLAG] = crc_flag;
                end
                OFS_LC_ENABLE: begin
                    next_st.rdata[3:0] = st.lc_en;
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st.ez_en <= RST_EZ_ENABLE;
            st.lc_en <= RST_LC_ENABLE;
            st.sa7_hist <= RST_SA7_HIST;
            st.sa7_zero <= 1'b0;
            st.rdata <= RST_RDATA;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata = st.rdata;
    // Interrupt from any flag whose enable is active; LOS and CRC are inverted
    assign irq = (ez_flag & st.ez_en[BIT_EXZ_EN])
        | (sa7_flag & st.ez_en[BIT_SA7_EN])
        | (los_flag & ~st.lc_en[BIT_LOS_EN])
        | (crc_flag & ~st.lc_en[BIT_CRC_EN]);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Sa7 window: a zero with another zero among the two before it declares
    a_sa7_two_zeros: assert property (@(posedge mclk) disable iff (!resetn)
        (sa7_valid && !sa7_bit && (st.sa7_hist[0] || st.sa7_hist[1])) |=> st.sa7_zero)
        else $error("two zero observations not declared");
    // Sa7 window: a one with at most one zero among the two before it clears the state
    a_sa7_one_zero: assert property (@(posedge mclk) disable iff (!resetn)
        (sa7_valid && sa7_bit && !(st.sa7_hist[0] && st.sa7_hist[1])) |=> !st.sa7_zero)
        else $error("Sa7 zero held with under two zeros");
    a_sa7_stable_idle: assert property (@(posedge mclk) disable iff (!resetn)
        !sa7_valid |=> $stable(st.sa7_zero)) else $error("Sa7 state moved without observation");
    a_sa7_leave_flag: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(st.sa7_zero) |=> sa7_flag) else $error("leaving Sa7 zero not flagged");
    a_sa7_irq_gate: assert property (@(posedge mclk) disable iff (!resetn)
        (sa7_flag && !st.ez_en[BIT_SA7_EN] && !ez_flag && !los_flag && !crc_flag) |-> !irq)
        else $error("disabled Sa7 flag raised irq");
    a_exz_irq_both: assert property (@(posedge mclk) disable iff (!resetn)
        ($changed(excess_zero_cond) && st.ez_en[BIT_EXZ_EN] && !wr_en_ez) |=> irq)
        else $error("excess-zero change gave no irq");
    a_ts16_live_read: assert property (@(posedge mclk) disable iff (!resetn)
        rd_lc |=> rdata[BIT_TS16] == $past(ts16_all_ones_alarm))
        else $error("TS16 read not live");
    a_los_read_clear: assert property (@(posedge mclk) disable iff (!resetn)
        (rd_lc && los_flag && !los_change) |=> (rdata[BIT_LOS_FLAG] && !los_flag))
        else $error("LOS read did not report and clear");
    a_los_irq_polarity: assert property (@(posedge mclk) disable iff (!resetn)
        (los_flag && !st.lc_en[BIT_LOS_EN]) |-> irq) else $error("LOS zero enable ignored");
    // CRC lock enable follows the same zero-enables polarity as LOS
    a_crc_irq_polarity: assert property (@(posedge mclk) disable iff (!resetn)
        (crc_flag && !st.lc_en[BIT_CRC_EN]) |-> irq) else $error("CRC zero enable ignored");
    a_irq_quiet: assert property (@(posedge mclk) disable iff (!resetn)
        (!ez_flag && !sa7_flag && !los_flag && !crc_flag) |-> !irq)
        else $error("irq without flag");
    c_sa7_declare: cover property (@(posedge mclk) disable iff (!resetn) $rose(st.sa7_zero));
    c_los_irq_clear: cover property (@(posedge mclk) disable iff (!resetn) irq ##1 rd_lc ##1 !irq);
    c_set_and_clear: cover property (@(posedge mclk) disable iff (!resetn) rd_lc && crc_change);
    c_crc_irq_zero_en: cover property (@(posedge mclk) disable iff (!resetn) crc_flag && !st.lc_en[BIT_CRC_EN]);
endmodule
`default_nettype wire

// File: tb/ezr_host_model.sv
// Purpose: Host processor model driving the register port
// Assumes: Strobes are sampled on the rising edge of mclk
// Notes:   Released address and data show inverted values
`timescale 1ns/100ps
`default_nettype none
module ezr_host_model (
    input wire logic mclk,
    output logic cs,
    output logic rd,
    output logic wr,
    output logic [ezr_pkg::ADDR_W-1:0] addr,
    output logic [ezr_pkg::DATA_W-1:0] wdata
);
    import ezr_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        cs = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = '0;
        wdata = '0;
    end
    // One strobe cycle between falling edges; a read acknowledges flags
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        cs = 1'b1;
        rd = !w;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge mclk);
        cs = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for the receive alarm interrupt registers
// Assumes: Read data settles one cycle after the read strobe
// Notes:   Expected read data queued by the driver, checked by a monitor
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ezr_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic sa7_valid = 1'b0;
    logic sa7_bit = 1'b0;
    logic ezc = 1'b0;
    logic ts16 = 1'b0;
    logic los = 1'b0;
    logic crc = 1'b0;
    logic cs, rd, wr, irq, rd_seen;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, r;
    logic [DATA_W-1:0] exp_q[$];
    // Mapped offsets plus one unmapped place
    localparam logic [3:0] OFS_LIST[5] = '{OFS_EZ_STATUS, OFS_EZ_ENABLE, OFS_LC_STATUS, OFS_LC_ENABLE, 4'hf};
    int fail_count = 0;
    int checks = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock, design and host
    always #20 mclk = ~mclk;
    ezr_rx_alarm_irq dut_u (.mclk(mclk), .resetn(resetn), .sa7_valid(sa7_valid), .sa7_bit(sa7_bit),
        .excess_zero_cond(ezc), .ts16_all_ones_alarm(ts16), .rx_signal_loss(los), .crc_mf_lock(crc),
        .cs(cs), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata), .rdata(rdata), .irq(irq));
    ezr_host_model host_u (.mclk(mclk), .cs(cs), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata));
    ////////////////////////////////////////////////////////////////////////
    // Compare tasks
    task automatic cmp_rdata(input logic [7:0] e);
        checks++;
        if (rdata !== e) begin
            fail_count++;
            $display("[FAIL] rdata expected %h seen %h", e, rdata);
        end
    endtask
    task automatic cmp_irq(input logic e);
        checks++;
        if (irq !== e) begin
            fail_count++;
            $display("[FAIL] irq expected %b seen %b", e, irq);
        end
    endtask
    // Monitor: a read taken at a rising edge is answered by the next falling edge
    always @(posedge mclk) begin
        rd_seen <= cs && rd && resetn;
    end
    always @(negedge mclk) begin
        if (rd_seen) begin
            cmp_rdata(exp_q.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Stimulus helpers
    task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.access(1'b0, a, 8'h00);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        host_u.access(1'b1, a, d);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic sa7_obs(input logic b);
        @(negedge mclk);
        sa7_valid = 1'b1;
        sa7_bit = b;
        @(negedge mclk);
        sa7_valid = 1'b0;
        sa7_bit = ~b;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog at 1000 cycles, far beyond the hundred or so cycles the tests need
    initial begin
        #40000;
        fail_count++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'hd1c6));
        wait_cyc(5);
        resetn = 1'b1;
        wait_cyc(1);
        foreach (OFS_LIST[i]) rd_exp(OFS_LIST[i], 8'h00);
        cmp_irq(1'b0);
        r = 8'($urandom);
        wr_reg(OFS_EZ_ENABLE, r);
        rd_exp(OFS_EZ_ENABLE, {6'h00, r[1:0]});
        r = 8'($urandom);
        wr_reg(OFS_LC_ENABLE, r);
        rd_exp(OFS_LC_ENABLE, {4'h0, r[3:0]});
        wr_reg(OFS_EZ_ENABLE, 8'h00);
        wr_reg(OFS_LC_ENABLE, 8'hff);
        $display("test reset and enables done");
        ezc = 1'b1;
        wait_cyc(3);
        cmp_irq(1'b0);
        wr_reg(OFS_EZ_ENABLE, 8'h01);
        cmp_irq(1'b1);
        rd_exp(OFS_EZ_STATUS, 8'h01);
        cmp_irq(1'b0);
        ezc = 1'b0;
        wait_cyc(3);
        cmp_irq(1'b1);
        wr_reg(OFS_EZ_STATUS, 8'h01);
        cmp_irq(1'b0);
        $display("test excess zero done");
        wr_reg(OFS_EZ_ENABLE, 8'h02);
        sa7_obs(1'b0);
        wait_cyc(3);
        cmp_irq(1'b0);
        rd_exp(OFS_EZ_STATUS, 8'h00);
        sa7_obs(1'b1);
        sa7_obs(1'b0);
        wait_cyc(3);
        cmp_irq(1'b1);
        rd_exp(OFS_EZ_STATUS, 8'h22);
        rd_exp(OFS_EZ_STATUS, 8'h20);
        sa7_obs(1'b1);
        wait_cyc(3);
        cmp_irq(1'b1);
        rd_exp(OFS_EZ_STATUS, 8'h02);
        wr_reg(OFS_EZ_ENABLE, 8'h00);
        $display("test sa7 done");
        ts16 = 1'b1;
        los = 1'b1;
        crc = 1'b1;
        wait_cyc(3);
        cmp_irq(1'b0);
        rd_exp(OFS_LC_STATUS, 8'h1c);
        rd_exp(OFS_LC_STATUS, 8'h10);
        wr_reg(OFS_LC_ENABLE, 8'h04);
        los = 1'b0;
        wait_cyc(3);
        cmp_irq(1'b1);
        wr_reg(OFS_LC_STATUS, 8'h08);
        cmp_irq(1'b0);
        crc = 1'b0;
        wait_cyc(3);
        cmp_irq(1'b0);
        rd_exp(OFS_LC_STATUS, 8'h14);
        ts16 = 1'b0;
        wait_cyc(2);
        rd_exp(OFS_LC_STATUS, 8'h00);
        wait_cyc(2);
        // CRC lock change in the very cycle of a status read: the set wins
        fork
            rd_exp(OFS_LC_STATUS, 8'h00);
            begin
                @(negedge mclk);
                crc = 1'b1;
            end
        join
        wr_reg(OFS_LC_ENABLE, 8'h00);
        cmp_irq(1'b1);
        rd_exp(OFS_LC_STATUS, 8'h04);
        cmp_irq(1'b0);
        $display("test los crc done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
